// ===== src/fbm_pkg.sv
/*
  Constants and types shared by the host-side flash bus controller.
  Assumes a 10 MHz system clock and an asynchronous parallel NOR flash on the far side.
*/
package fbm_pkg;
  // timing, ns at 100 ns clock period
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_CE_NS = 55;
  localparam int T_WP_NS = 35;
  localparam int T_RP_NS = 500;
  localparam int T_RH_NS = 200;
  localparam int T_READY_NS = 20000;
  // least times round up
  localparam int CE_CYC = (T_CE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RH_CYC = (T_RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READY_CYC = (T_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // unlock addresses and command codes
  localparam logic [22:0] UNLOCK_ADDR1 = 23'h000555;
  localparam logic [22:0] UNLOCK_ADDR2 = 23'h0002aa;
  localparam logic [15:0] UNLOCK_DATA1 = 16'h00aa;
  localparam logic [15:0] UNLOCK_DATA2 = 16'h0055;
  localparam logic [15:0] CMD_PROGRAM = 16'h00a0;
  localparam logic [15:0] CMD_BYPASS_ENTER = 16'h0020;
  localparam logic [15:0] CMD_AUTOSEL = 16'h0090;
  localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
  localparam logic [15:0] CMD_CHIP_ERASE = 16'h0010;
  localparam logic [15:0] CMD_SECTOR_ERASE = 16'h0030;
  localparam logic [15:0] CMD_RESET = 16'h00f0;
  localparam logic [15:0] CMD_BYPASS_EXIT1 = 16'h0090;
  localparam logic [15:0] CMD_BYPASS_EXIT2 = 16'h0000;
  // host-side operation codes
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_PROGRAM = 3'h1;
  localparam logic [2:0] OP_SECTOR_ERASE = 3'h2;
  localparam logic [2:0] OP_CHIP_ERASE = 3'h3;
  localparam logic [2:0] OP_AUTOSEL = 3'h4;
  localparam logic [2:0] OP_BYPASS_ENTER = 3'h5;
  localparam logic [2:0] OP_BYPASS_EXIT = 3'h6;
  localparam logic [2:0] OP_ARRAY_READ = 3'h7;
  typedef enum {
    ST_RESET, ST_RECOVER, ST_IDLE, ST_RD_WAIT, ST_WR_SETUP, ST_WR_LOW, ST_WR_HIGH,
    ST_BUSY_WAIT, ST_DONE
  } fbm_state_type;
endpackage

// ===== src/fbm_host.sv
/*
  Host controller driving a parallel NOR flash through its pins: reset, select,
  output gate, write strobe, address, data and the accelerate pin.
  Assumes busy_indicator_n and data inputs are synchronous to clk_in; the flash has
  no clock and all device delays are met by whole-cycle waits.
*/
`timescale 1ns/1ps
module fbm_host import fbm_pkg::*; #(
  parameter int READY_CYCLES = READY_CYC,
  parameter int MAX_SECTORS = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  // user side
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire logic [2:0] req_op_in,
  input wire logic [22:0] req_addr_in,
  input wire logic [15:0] req_data_in,
  input wire logic [3:0] req_count_in,
  input wire logic accel_req_in,
  output logic rsp_valid_out,
  output logic [15:0] rsp_data_out,
  output logic bypass_active_out,
  // flash pins
  output logic reset_n_out,
  output logic lower_half_select_n_out,
  output logic output_gate_n_out,
  output logic write_strobe_n_out,
  output logic [22:0] addr_out,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic dq_oe_out,
  output logic protect_accel_pin_out,
  input wire logic busy_indicator_n_in
);
  localparam int CW = $clog2(READY_CYCLES + 2);
  // ==========================================================================
  // write sequence table
  // one bus write of a command sequence; idx walks the sequence
  function automatic logic [38:0] seq_word(input logic [2:0] op, input logic [3:0] idx,
                                           input logic bypass, input logic [22:0] a,
                                           input logic [15:0] d);
    logic [38:0] w;
    w = {UNLOCK_ADDR1, CMD_RESET};
    case (idx)
      4'h0: w = {UNLOCK_ADDR1, UNLOCK_DATA1};
      4'h1: w = {UNLOCK_ADDR2, UNLOCK_DATA2};
      4'h2: w = {UNLOCK_ADDR1, (op == OP_PROGRAM) ? CMD_PROGRAM : (op == OP_AUTOSEL) ? CMD_AUTOSEL :
                 (op == OP_BYPASS_ENTER) ? CMD_BYPASS_ENTER : CMD_ERASE_SETUP};
      4'h3: w = {UNLOCK_ADDR1, UNLOCK_DATA1};
      4'h4: w = {UNLOCK_ADDR2, UNLOCK_DATA2};
      default: w = {a, CMD_SECTOR_ERASE};
    endcase
    if (op == OP_PROGRAM && idx == 4'h3) w = {a, d};
    if (op == OP_CHIP_ERASE && idx == 4'h5) w = {UNLOCK_ADDR1, CMD_CHIP_ERASE};
    if (op == OP_ARRAY_READ) w = {UNLOCK_ADDR1, CMD_RESET};
    // bypass program and exit are two writes
    if (bypass && op == OP_PROGRAM) w = (idx == 4'h0) ? {UNLOCK_ADDR1, CMD_PROGRAM} : {a, d};
    if (op == OP_BYPASS_EXIT) w = (idx == 4'h0) ? {UNLOCK_ADDR1, CMD_BYPASS_EXIT1}
                                                : {UNLOCK_ADDR1, CMD_BYPASS_EXIT2};
    return w;
  endfunction
  // last write index of each sequence
  function automatic logic [3:0] seq_last(input logic [2:0] op, input logic bypass, input logic [3:0] n);
    case (op)
      OP_PROGRAM: seq_last = bypass ? 4'h1 : 4'h3;
      OP_SECTOR_ERASE: seq_last = 4'h5 + n;
      OP_CHIP_ERASE: seq_last = 4'h5;
      OP_BYPASS_EXIT: seq_last = 4'h1;
      OP_ARRAY_READ: seq_last = 4'h0;
      default: seq_last = 4'h2;
    endcase
  endfunction

  // ==========================================================================
  // state registers
  fbm_state_type state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [3:0] idx_q, idx_d;
  logic [2:0] op_q, op_d;
  logic [22:0] addr_q, addr_d;
  logic [15:0] data_q, data_d;
  logic [3:0] count_q, count_d;
  logic bypass_q, bypass_d;
  logic accel_q, accel_d;
  logic sel_n_q, sel_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d, drive_q, drive_d, rst_n_q, rst_n_d;
  logic [22:0] pin_addr_q, pin_addr_d;
  logic [15:0] pin_data_q, pin_data_d, rsp_q, rsp_d;
  logic rsp_v_q, rsp_v_d;
  logic [38:0] w;

  // next-state logic
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    idx_d = idx_q;
    op_d = op_q;
    addr_d = addr_q;
    data_d = data_q;
    count_d = count_q;
    bypass_d = bypass_q;
    accel_d = accel_q;
    sel_n_d = sel_n_q;
    oe_n_d = 1'b1;
    we_n_d = 1'b1;
    drive_d = 1'b0;
    rst_n_d = 1'b1;
    pin_addr_d = pin_addr_q;
    pin_data_d = pin_data_q;
    rsp_d = rsp_q;
    rsp_v_d = 1'b0;
    w = seq_word(op_q, idx_q, bypass_q, addr_q, data_q);
    case (state_q)
      ST_RESET: begin
        // reset pulse of at least the minimum width; device aborts and tristates
        rst_n_d = 1'b0;
        sel_n_d = 1'b1;
        cnt_d = cnt_q + 1'b1;
        if (cnt_q >= CW'(RP_CYC)) begin // the pin trails the state by one cycle, so count one more
          rst_n_d = 1'b1;
          cnt_d = '0;
          bypass_d = 1'b0;
          state_d = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        // recovery time, then busy high, bounded by the embedded ready time
        cnt_d = cnt_q + 1'b1;
        if ((cnt_q >= CW'(RH_CYC - 1) && busy_indicator_n_in) || cnt_q >= CW'(READY_CYCLES)) begin
          cnt_d = '0;
          // only a timeout leaves a write op here; a dead device is reset and retried without end
          state_d = (op_q == OP_PROGRAM || op_q == OP_SECTOR_ERASE || op_q == OP_CHIP_ERASE)
                    ? ST_WR_SETUP : ST_IDLE;
        end
      end
      ST_IDLE: begin
        sel_n_d = 1'b1; // standby between accesses
        // accel pin only raised on request and only while idle
        accel_d = accel_req_in;
        if (accel_q) bypass_d = 1'b1;
        if (accel_q && !accel_req_in) bypass_d = 1'b0;
        if (req_valid_in) begin
          op_d = req_op_in;
          addr_d = req_addr_in;
          data_d = req_data_in;
          count_d = (req_count_in >= 4'(MAX_SECTORS)) ? 4'(MAX_SECTORS - 1) : req_count_in;
          idx_d = '0;
          cnt_d = '0;
          pin_addr_d = req_addr_in;
          sel_n_d = 1'b0;
          if (req_op_in == OP_READ) begin
            oe_n_d = 1'b0;
            state_d = ST_RD_WAIT;
          end else begin
            state_d = ST_WR_SETUP;
          end
        end
      end
      ST_RD_WAIT: begin
        // from standby allow full select access time before sampling
        oe_n_d = 1'b0;
        cnt_d = cnt_q + 1'b1;
        if (cnt_q >= CW'(CE_CYC - 1)) begin
          rsp_d = dq_in; // autoselect codes come back here too
          rsp_v_d = 1'b1;
          sel_n_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_WR_SETUP: begin
        sel_n_d = 1'b0;
        pin_addr_d = w[38:16];
        pin_data_d = w[15:0];
        drive_d = 1'b1;
        cnt_d = '0;
        state_d = ST_WR_LOW;
      end
      ST_WR_LOW: begin
        // strobe and select low, gate high
        we_n_d = 1'b0;
        drive_d = 1'b1;
        cnt_d = cnt_q + 1'b1;
        if (cnt_q >= CW'(WP_CYC - 1)) begin
          // strobe stays low here; the high state raises it, so the pulse is WP_CYC cycles
          state_d = ST_WR_HIGH;
        end
      end
      ST_WR_HIGH: begin
        drive_d = 1'b1;
        if (idx_q == seq_last(op_q, bypass_q, count_q)) begin
          cnt_d = '0;
          sel_n_d = 1'b1; // deselect is safe; device finishes the work
          if (op_q == OP_BYPASS_ENTER) bypass_d = 1'b1;
          if (op_q == OP_BYPASS_EXIT || op_q == OP_ARRAY_READ) bypass_d = accel_q;
          state_d = (op_q == OP_PROGRAM || op_q == OP_SECTOR_ERASE || op_q == OP_CHIP_ERASE)
                    ? ST_BUSY_WAIT : ST_DONE;
        end else begin
          idx_d = idx_q + 1'b1;
          if (idx_q >= 4'h5) addr_d = addr_q + 23'h008000; // next sector of the set
          state_d = ST_WR_SETUP;
        end
      end
      ST_BUSY_WAIT: begin
        // busy low during embedded work; timeout restarts via reset
        cnt_d = cnt_q + 1'b1;
        if (cnt_q >= CW'(2) && busy_indicator_n_in) state_d = ST_DONE;
        else if (cnt_q >= CW'(READY_CYCLES)) begin
          cnt_d = '0;
          idx_d = '0;
          if (op_q == OP_SECTOR_ERASE) addr_d = addr_q - 23'({count_q, 15'h0000});
          state_d = ST_RESET;
        end
      end
      ST_DONE: begin
        rsp_v_d = 1'b1;
        state_d = ST_IDLE;
      end
      default: state_d = ST_RESET;
    endcase
  end

  // registers only
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_RESET;
      cnt_q <= '0;
      idx_q <= '0;
      op_q <= OP_READ;
      addr_q <= '0;
      data_q <= '0;
      count_q <= '0;
      bypass_q <= 1'b0;
      accel_q <= 1'b0;
      sel_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      drive_q <= 1'b0;
      rst_n_q <= 1'b0;
      pin_addr_q <= '0;
      pin_data_q <= '0;
      rsp_q <= '0;
      rsp_v_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      op_q <= op_d;
      addr_q <= addr_d;
      data_q <= data_d;
      count_q <= count_d;
      bypass_q <= bypass_d;
      accel_q <= accel_d;
      sel_n_q <= sel_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      drive_q <= drive_d;
      rst_n_q <= rst_n_d;
      pin_addr_q <= pin_addr_d;
      pin_data_q <= pin_data_d;
      rsp_q <= rsp_d;
      rsp_v_q <= rsp_v_d;
    end
  end

  // ==========================================================================
  // outputs
  assign req_ready_out = (state_q == ST_IDLE);
  assign rsp_valid_out = rsp_v_q;
  assign rsp_data_out = rsp_q;
  assign bypass_active_out = bypass_q;
  assign reset_n_out = rst_n_q;
  assign lower_half_select_n_out = sel_n_q;
  assign output_gate_n_out = oe_n_q;
  assign write_strobe_n_out = we_n_q;
  assign addr_out = pin_addr_q;
  assign dq_out = pin_data_q;
  assign dq_oe_out = drive_q;
  assign protect_accel_pin_out = accel_q;

  // ==========================================================================
  // assertions
  a_write_gate_high: assert property (@(posedge clk_in) disable iff (rst_in)
    !write_strobe_n_out |-> (output_gate_n_out && !lower_half_select_n_out && dq_oe_out))
    else $error("write strobe low without select low and gate high");
  a_reset_min_width: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(reset_n_out) |-> !reset_n_out [*5])
    else $error("reset pulse shorter than minimum width");
  a_read_waits_access: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(state_q == ST_RD_WAIT) |-> !rsp_v_q [*2])
    else $error("read sampled before select access time");
  a_bypass_two_writes: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == ST_IDLE && req_valid_in && req_op_in == OP_PROGRAM && bypass_q) |->
    ##[1:20] (state_q == ST_WR_HIGH && idx_q == 4'h1) ##1 (state_q == ST_BUSY_WAIT))
    else $error("bypass program not two writes");
  a_recover_before_use: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(reset_n_out) |-> !req_ready_out [*2])
    else $error("request accepted inside recovery time");
  a_accel_idle_only: assert property (@(posedge clk_in) disable iff (rst_in)
    $changed(protect_accel_pin_out) |-> $past(state_q) == ST_IDLE)
    else $error("accelerate pin changed outside idle");
  a_no_drive_in_reset: assert property (@(posedge clk_in) disable iff (rst_in)
    !reset_n_out |-> (!dq_oe_out && write_strobe_n_out))
    else $error("bus driven during device reset");
  a_busy_holds_wait: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == ST_BUSY_WAIT && cnt_q >= CW'(2) && !busy_indicator_n_in && cnt_q < CW'(READY_CYCLES))
    |=> state_q == ST_BUSY_WAIT)
    else $error("left busy wait while device busy");
endmodule

// ===== dv/fbm_flash_model.sv
/*
  Behavioural model of the parallel flash device facing the host controller.
  Assumes the host moves its pins on rising clk_in edges; the model samples on the same edges.
*/
`timescale 1ns/1ps
module fbm_flash_model #(
  parameter int OP_BUSY = 6,
  parameter int RST_BUSY = 12,
  parameter logic [15:0] MAKER_CODE = 16'h00c3, // arbitrary value
  parameter logic [15:0] PART_CODE = 16'h0a5a // arbitrary value
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic select_n_in,
  input wire logic gate_n_in,
  input wire logic strobe_n_in,
  input wire logic [22:0] addr_in,
  input wire logic [15:0] dq_in,
  input wire logic accel_in,
  output logic [15:0] dq_out,
  output logic busy_n_out
);
  logic [15:0] mem [int];
  logic [15:0] last_q = 16'h0000;
  logic [15:0] pd;
  logic [22:0] pa;
  logic [3:0] stage = 4'h0;
  logic bypass = 1'b0;
  logic autosel = 1'b0;
  logic pend = 1'b0;
  logic strobe_q = 1'b1;
  logic accel_q = 1'b0;
  int busy_cnt = 0;
  // ======
  // busy while a program waits or any countdown runs
  assign busy_n_out = (busy_cnt == 0) && !pend;
  function automatic logic [15:0] rd(input logic [22:0] a);
    if (autosel) return (a[7:0] == 8'h00) ? MAKER_CODE : PART_CODE;
    return mem.exists(int'(a)) ? mem[int'(a)] : 16'hffff;
  endfunction
  // ======
  // command decoder, one call per falling write strobe
  task automatic take(input logic [22:0] a, input logic [15:0] d);
    logic first;
    first = (d == 16'h00aa) && (a[10:0] == 11'h555);
    if (d == 16'h00f0) begin
      autosel <= 1'b0;
      stage <= 4'h0;
    end else case (stage)
      4'h0: begin
        if (bypass && d == 16'h00a0) stage <= 4'h3;
        else if (bypass && d == 16'h0090) stage <= 4'h7;
        else if (first) stage <= 4'h1;
      end
      4'h1, 4'h5: stage <= (d == 16'h0055 && a[10:0] == 11'h2aa) ? stage + 4'h1 : 4'h0;
      4'h2: begin
        stage <= (d == 16'h00a0) ? 4'h3 : (d == 16'h0080) ? 4'h4 : 4'h0;
        if (d == 16'h0020) bypass <= 1'b1;
        if (d == 16'h0090) autosel <= 1'b1;
      end
      4'h3: begin
        pa <= a;
        pd <= d;
        pend <= 1'b1;
        busy_cnt <= OP_BUSY;
        stage <= 4'h0;
      end
      4'h4: stage <= first ? 4'h5 : 4'h0;
      4'h6: begin
        // erase lands at once; the busy window only shows the work as running
        if (d == 16'h0010 || d == 16'h0030) begin
          foreach (mem[k]) if (d == 16'h0010 || k[22:15] == a[22:15]) mem[k] = 16'hffff;
          busy_cnt <= OP_BUSY * 2;
        end
        stage <= (d == 16'h0030) ? 4'h6 : first ? 4'h1 : 4'h0;
      end
      default: begin
        if (d == 16'h0000) bypass <= 1'b0;
        stage <= 4'h0;
      end
    endcase
  endtask
  // ======
  // pins; a released data bus shows the inverse of its last value, never a steady copy
  always @(posedge clk_in) begin
    strobe_q <= strobe_n_in;
    accel_q <= accel_in;
    if (reset_n_in && !select_n_in && !gate_n_in) begin
      dq_out <= rd(addr_in);
      last_q <= rd(addr_in);
    end else begin
      dq_out <= ~last_q;
    end
    if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
    end else if (pend) begin
      mem[int'(pa)] = pd;
      pend <= 1'b0;
    end
    if (!reset_n_in) begin
      if (pend) busy_cnt <= RST_BUSY;
      pend <= 1'b0;
      stage <= 4'h0;
      autosel <= 1'b0;
      bypass <= accel_in;
    end else begin
      if (accel_in && !accel_q) bypass <= 1'b1;
      if (!accel_in && accel_q) bypass <= 1'b0;
      if (!select_n_in && gate_n_in && !strobe_n_in && strobe_q) take(addr_in, dq_in);
    end
  end
endmodule

// ===== dv/fbm_host_test.sv
/*
  Self-checking bench for the host flash controller with a behavioural device model.
  Assumes the package constants and a shortened ready timeout of 20 cycles.
*/
`timescale 1ns/1ps
module fbm_host_test;
  import fbm_pkg::*;
  localparam logic [15:0] MAKER = 16'h00c3; // arbitrary value
  localparam logic [15:0] PART = 16'h0a5a; // arbitrary value
  logic clk = 1'b0;
  logic rst_in = 1'b1;
  logic req_valid = 1'b0;
  logic accel_req = 1'b0;
  logic [2:0] req_op = 3'h0;
  logic [22:0] req_addr = 23'h000000;
  logic [15:0] req_data = 16'h0000;
  logic [3:0] req_count = 4'h0;
  logic req_ready, rsp_valid, bypass_on, reset_n, sel_n, gate_n, strobe_n, dq_oe, accel_pin, busy_n;
  logic [15:0] rsp_data, h_dq, m_dq, got;
  logic [22:0] addr;
  int n_fail = 0;
  int samples_checked = 0;
  int wr_cnt = 0;
  int nw = 0;
  // the data wire follows whoever enables it
  wire [15:0] dq_bus = dq_oe ? h_dq : m_dq;
  always #50 clk = ~clk;
  always @(negedge strobe_n) wr_cnt++;
  fbm_host #(.READY_CYCLES(20)) dut_u (.clk_in(clk), .rst_in(rst_in), .req_valid_in(req_valid),
    .req_ready_out(req_ready), .req_op_in(req_op), .req_addr_in(req_addr), .req_data_in(req_data),
    .req_count_in(req_count), .accel_req_in(accel_req), .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data),
    .bypass_active_out(bypass_on), .reset_n_out(reset_n), .lower_half_select_n_out(sel_n),
    .output_gate_n_out(gate_n), .write_strobe_n_out(strobe_n), .addr_out(addr), .dq_in(dq_bus),
    .dq_out(h_dq), .dq_oe_out(dq_oe), .protect_accel_pin_out(accel_pin), .busy_indicator_n_in(busy_n));
  fbm_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) flash_u (.clk_in(clk), .reset_n_in(reset_n),
    .select_n_in(sel_n), .gate_n_in(gate_n), .strobe_n_in(strobe_n), .addr_in(addr), .dq_in(dq_bus),
    .accel_in(accel_pin), .dq_out(m_dq), .busy_n_out(busy_n));
  // ======
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic final_report();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic give_up();
    n_fail++;
    final_report();
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 400; i++) begin
      @(negedge clk);
      if (req_ready === 1'b1) return;
    end
    give_up();
  endtask
  // request is held from one rising edge to the next, where ready is high in idle
  task automatic issue(input logic [2:0] op, input logic [22:0] a, input logic [15:0] d, input logic [3:0] c);
    wait_ready();
    @(posedge clk);
    req_op <= op;
    req_addr <= a;
    req_data <= d;
    req_count <= c;
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
  endtask
  task automatic do_op(input logic [2:0] op, input logic [22:0] a, input logic [15:0] d, input logic [3:0] c);
    int w0;
    w0 = wr_cnt;
    issue(op, a, d, c);
    for (int i = 0; i < 400; i++) begin
      @(negedge clk);
      if (rsp_valid === 1'b1) begin
        got = rsp_data;
        nw = wr_cnt - w0;
        return;
      end
    end
    give_up();
  endtask
  task automatic rd_chk(input logic [22:0] a, input logic [15:0] e);
    do_op(OP_READ, a, 16'h0000, 4'h0);
    check(got, e);
  endtask
  task automatic wait_bypass(input logic v);
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      if (bypass_on === v) return;
    end
    give_up();
  endtask
  // ======
  task automatic s_startup();
    int n;
    n = 0;
    for (int i = 0; i < 50 && reset_n !== 1'b1; i++) begin
      @(negedge clk);
      n++;
    end
    check(16'(n >= RP_CYC), 16'h0001);
    check(16'(busy_n), 16'h0001);
  endtask
  task automatic s_program();
    do_op(OP_PROGRAM, 23'h000123, 16'h5a3c, 4'h0);
    check(16'(nw), 16'h0004);
    rd_chk(23'h000123, 16'h5a3c);
  endtask
  task automatic s_bypass();
    do_op(OP_BYPASS_ENTER, 23'h000000, 16'h0000, 4'h0);
    check(16'(bypass_on), 16'h0001);
    do_op(OP_PROGRAM, 23'h008010, 16'h7777, 4'h0);
    check(16'(nw), 16'h0002);
    rd_chk(23'h008010, 16'h7777);
    do_op(OP_BYPASS_EXIT, 23'h000000, 16'h0000, 4'h0);
    check(16'(nw + 16 * bypass_on), 16'h0002);
  endtask
  // elevated voltage only around accelerated programs, dropped straight after
  task automatic s_accel();
    @(posedge clk);
    accel_req <= 1'b1;
    wait_bypass(1'b1);
    check(16'(accel_pin), 16'h0001);
    do_op(OP_PROGRAM, 23'h010000, 16'h8888, 4'h0);
    check(16'(nw), 16'h0002);
    @(posedge clk);
    accel_req <= 1'b0;
    wait_bypass(1'b0);
    check(16'(accel_pin), 16'h0000);
    do_op(OP_PROGRAM, 23'h000124, 16'hc3a5, 4'h0);
    check(16'(nw), 16'h0004);
    rd_chk(23'h010000, 16'h8888);
  endtask
  task automatic s_autosel();
    do_op(OP_AUTOSEL, 23'h000000, 16'h0000, 4'h0);
    check(16'(nw), 16'h0003);
    rd_chk(23'h000000, MAKER);
    rd_chk(23'h000001, PART);
    do_op(OP_ARRAY_READ, 23'h000000, 16'h0000, 4'h0);
    rd_chk(23'h000124, 16'hc3a5);
  endtask
  task automatic s_erase();
    do_op(OP_SECTOR_ERASE, 23'h000000, 16'h0000, 4'h1);
    check(16'(nw), 16'h0007);
    rd_chk(23'h000123, 16'hffff);
    rd_chk(23'h008010, 16'hffff);
    rd_chk(23'h010000, 16'h8888);
    do_op(OP_CHIP_ERASE, 23'h000000, 16'h0000, 4'h0);
    check(16'(nw), 16'h0006);
    rd_chk(23'h010000, 16'hffff);
  endtask
  // reset lands while the device is busy programming
  task automatic s_reset_mid();
    issue(OP_PROGRAM, 23'h000300, 16'h4321, 4'h0);
    for (int i = 0; i < 50 && busy_n !== 1'b0; i++) @(negedge clk);
    if (busy_n !== 1'b0) give_up();
    @(posedge clk);
    rst_in <= 1'b1;
    @(posedge clk);
    rst_in <= 1'b0;
    @(negedge clk);
    check(16'(reset_n), 16'h0000);
    check(16'(busy_n), 16'h0000);
    rd_chk(23'h000300, 16'hffff);
  endtask
  // ======
  initial begin
    repeat (3) @(posedge clk);
    rst_in <= 1'b0;
    s_startup();
    s_program();
    s_bypass();
    s_accel();
    s_autosel();
    s_erase();
    s_reset_mid();
    final_report();
  end
endmodule
